// ### logic/stop_recovery_and_watchdog_ctrl.sv
`timescale 1ns/1ps
module stop_recovery_and_watchdog_ctrl
    import stop_wdt_pkg::*;
#(
    parameter bit PERMANENT = 1'b0,                // Permanent watchdog option
    parameter int RC_CYC0   = stop_wdt_pkg::WDT_RC_CYC0,
    parameter int RC_CYC1   = stop_wdt_pkg::WDT_RC_CYC1,
    parameter int RC_CYC2   = stop_wdt_pkg::WDT_RC_CYC2,
    parameter int RC_CYC3   = stop_wdt_pkg::WDT_RC_CYC3
) (
    input  wire logic                     pclk,          // 125 MHz clock
    input  wire logic                     presetn,       // Async reset, low
    input  wire logic                     psel,          // APB select
    input  wire logic                     penable,       // APB enable
    input  wire logic                     pwrite,        // APB direction
    input  wire logic [11:0]              paddr,         // APB byte address
    input  wire logic [31:0]              pwdata,        // APB write data
    output logic      [31:0]              prdata,        // APB read data
    output logic                          pready,        // APB ready
    output logic                          pslverr,       // APB error
    input  wire stop_wdt_pkg::wake_pins_s pins,          // Wake pins
    input  wire stop_wdt_pkg::cpu_state_s cpu,           // CPU state
    input  wire logic                     supply_low,    // Comparator pin
    output logic                          sclk_tick,     // System clock enable
    output logic                          wake_pulse,    // Stop wake event
    output logic                          wdt_reset,     // Watchdog timeout
    output logic                          por_start,     // Start delay timer
    output logic                          global_reset   // Low voltage reset
);
    import stop_wdt_pkg::*;

    // ============================================================
    // Helpers
    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction

    function automatic logic [23:0] wdt_limit(input logic [1:0] sel,
                                             input logic xtal);
        logic [11:0] s;
        int          r;
        s = 12'h000;
        r = 0;
        unique case (sel)
            2'd0: begin s = WDT_SCLK0; r = RC_CYC0; end
            2'd1: begin s = WDT_SCLK1; r = RC_CYC1; end
            2'd2: begin s = WDT_SCLK2; r = RC_CYC2; end
            2'd3: begin s = WDT_SCLK3; r = RC_CYC3; end
        endcase
        wdt_limit = xtal ? {12'h000, s} : r[23:0];
    endfunction

    typedef enum logic [1:0] {WIN_WAIT, WIN_OPEN, WIN_LOCKED} win_e;

    // ============================================================
    // Pin synchronisers: three stages, change taken when 2 and 3 agree
    localparam int SW = 13;
    logic [SW-1:0] s1_r, s2_r, s3_r, filt_r;              // Sync chain
    wire  [SW-1:0] pin_raw = {supply_low, pins.p3_in, pins.p2_in};

    // Stage one feeds only stage two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r   <= '0;
            s2_r   <= '0;
            s3_r   <= '0;
            filt_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < SW; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    filt_r[i] <= s3_r[i];
                end
            end
        end
    end

    wire       low_f  = filt_r[12];                        // Supply low
    wire [3:0] p3_f   = filt_r[11:8];                      // Port 3 sync
    // Output pins wake on the level being driven, not the pad
    wire [7:0] p2_eff = (pins.p2_is_out & pins.p2_out)
                      | (~pins.p2_is_out & filt_r[7:0]);

    // ============================================================
    // Registers
    logic [6:0]  ctrl_r;        // Control bits 6..0
    logic        warm_r;        // Warm start flag
    logic [1:0]  extra_r;       // Extra wake sources
    logic [4:0]  mode_r;        // Watchdog mode
    logic        wdt_en_r;      // Watchdog running
    logic [23:0] wdt_cnt_r;     // Watchdog counter
    logic [4:0]  div_cnt_r;     // Prescaler counter
    logic [5:0]  win_cnt_r;     // Write window count
    win_e        win_r;         // Write window state
    logic        woke_r;        // Wake or timeout already fired in this stop
    logic        low_d_r;       // Supply low, delayed

    // ============================================================
    // APB decode
    wire setup    = psel & ~penable;
    wire access   = psel & penable;
    wire hit_ctrl = paddr == byte_addr(IDX_CTRL);
    wire hit_ext  = paddr == byte_addr(IDX_EXTRA);
    wire hit_mode = paddr == byte_addr(IDX_MODE);
    wire hit_stat = paddr == byte_addr(IDX_STATUS);
    wire mapped   = hit_ctrl | hit_ext | hit_mode | hit_stat;
    wire wr       = access & pwrite & mapped;
    // Writes after the window closes complete but are dropped
    wire mode_ok  = win_r != WIN_LOCKED;
    wire wr_mode  = wr & hit_mode & mode_ok;

    // Answer in the access cycle, no wait states
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Read data: only the warm flag and status are visible
    wire [31:0] rd_mux = hit_ctrl ? {24'h0, warm_r, 7'h00}
                       : hit_stat ? {26'h0, (win_r == WIN_LOCKED),
                                     cpu.stop_mode, low_f, wdt_en_r,
                                     mode_ok, woke_r}
                       : 32'h0;

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
        end
    end

    // ============================================================
    // Clock prescaler: ratio 1, 2, 16 or 32 crystal clocks
    wire [4:0] div_ratio_m1 = ctrl_r[F_DIV16]
                            ? (ctrl_r[F_NODIV] ? 5'd15 : 5'd31)
                            : (ctrl_r[F_NODIV] ? 5'd0 : 5'd1);
    // Crystal stops in STOP, so no system ticks there
    wire       div_hit      = div_cnt_r >= div_ratio_m1;

    // Prescaler counter and registered tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= 5'd0;
            sclk_tick <= 1'b0;
        end else if (cpu.stop_mode) begin
            div_cnt_r <= 5'd0;
            sclk_tick <= 1'b0;
        end else begin
            div_cnt_r <= div_hit ? 5'd0 : div_cnt_r + 5'd1;
            sclk_tick <= div_hit;
        end
    end

    // ============================================================
    // Wake source selection
    wire       pol = ctrl_r[F_POL];
    wire [2:0] src = ctrl_r[F_SRC+:3];
    logic      src_lvl;                                     // Source level
    logic      src_on;                                      // Source chosen
    always_comb begin
        src_lvl = 1'b0;
        src_on  = 1'b1;
        unique case (src)
            3'd0:    src_on  = 1'b0;
            3'd1:    src_lvl = p3_f[0];
            3'd2:    src_lvl = p3_f[1];
            3'd3:    src_lvl = p3_f[2];
            3'd4:    src_lvl = p3_f[3];
            3'd5:    src_lvl = p2_eff[7];
            3'd6:    src_lvl = ~|p2_eff[3:0];
            3'd7:    src_lvl = ~|p2_eff;
        endcase
        // Port 3 bits 1..3 are not sources in analog mode
        if (cpu.analog_mode && src inside {3'd2, 3'd3, 3'd4}) begin
            src_on = 1'b0;
        end
    end
    // Extra sources; software keeps the other select at zero
    wire ext_lvl = extra_r == 2'd1 ? &p2_eff[3:0] : &p2_eff;
    wire ext_on  = extra_r == 2'd1 || extra_r == 2'd2;
    // Sync latency is four clocks, inside the five-clock hold
    wire wake_now = cpu.stop_mode & ~woke_r
                  & ((src_on & (src_lvl == pol))
                  | (ext_on & (ext_lvl == pol)));

    // ============================================================
    // Watchdog
    wire       xtal_src = mode_r[F_XTAL];
    wire       locked_on = PERMANENT & ~xtal_src;
    wire       run_ok   = locked_on
                        | ((~cpu.halt_mode | mode_r[F_HALT])
                        & (~cpu.stop_mode
                        | (mode_r[F_STOP] & ~xtal_src)));
    wire       cnt_tick = xtal_src ? sclk_tick : 1'b1;
    wire [23:0] limit   = wdt_limit(mode_r[F_TSEL+:2], xtal_src);
    wire       timeout  = wdt_en_r & run_ok & cnt_tick
                        & (wdt_cnt_r >= limit - 24'd1);
    wire       reset_ev = timeout | wake_now;

    // Counter: refresh clears it, terminal count fires a reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_r <= 24'd0;
            wdt_en_r  <= PERMANENT;
        end else if (reset_ev || low_f) begin
            // A low supply is a global reset, so it turns the watchdog off too unless PERMANENT is set
            wdt_cnt_r <= 24'd0;
            wdt_en_r  <= PERMANENT;
        end else if (cpu.wdt_instr) begin
            wdt_cnt_r <= 24'd0;
            wdt_en_r  <= 1'b1;
        end else if (wdt_en_r && run_ok && cnt_tick) begin
            wdt_cnt_r <= wdt_cnt_r + 24'd1;
        end
    end

    // ============================================================
    // Mode write window, counted in system clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_r     <= WIN_WAIT;
            win_cnt_r <= 6'd0;
        end else if (reset_ev || (low_d_r && !low_f)) begin
            win_r     <= WIN_WAIT;
            win_cnt_r <= 6'd0;
        end else begin
            unique case (win_r)
                WIN_WAIT: begin
                    if (cpu.first_instr) begin
                        win_r <= WIN_OPEN;
                    end
                end
                WIN_OPEN: begin
                    if (sclk_tick) begin
                        win_cnt_r <= win_cnt_r + 6'd1;
                        if (win_cnt_r == 6'(WIN_SCLK - 1)) begin
                            win_r <= WIN_LOCKED;
                        end
                    end
                end
                WIN_LOCKED: win_r <= WIN_LOCKED;
            endcase
        end
    end

    // ============================================================
    // Software registers; wake wins over a write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r  <= CTRL_RST;
            extra_r <= EXTRA_RST;
            mode_r  <= MODE_RST;
        end else if (low_f) begin
            // Supply fail restores power-on defaults
            ctrl_r  <= CTRL_RST;
            extra_r <= EXTRA_RST;
            mode_r  <= MODE_RST;
        end else begin
            if (wr && hit_ctrl) begin
                ctrl_r <= pwdata[6:0];
            end
            if (wr && hit_ext) begin
                extra_r <= pwdata[1:0];
            end
            if (wr_mode) begin
                mode_r <= pwdata[4:0];
            end
            // A stop timeout leaves ctrl_r, extra_r and mode_r as they were
            if (wake_now) begin
                ctrl_r[F_DIV16] <= 1'b0;
            end
        end
    end

    // ============================================================
    // Flags and event outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm_r       <= 1'b0;
            woke_r       <= 1'b0;
            low_d_r      <= 1'b0;
            wake_pulse   <= 1'b0;
            wdt_reset    <= 1'b0;
            por_start    <= 1'b0;
            global_reset <= 1'b0;
        end else begin
            low_d_r      <= low_f;
            global_reset <= low_f;
            wake_pulse   <= wake_now;
            wdt_reset    <= timeout;
            // Delay after timeout even if wake delay is off
            por_start    <= timeout
                          | (wake_now & ctrl_r[F_DELAY])
                          | (low_d_r & ~low_f);
            woke_r       <= cpu.stop_mode & (woke_r | reset_ev);
            if (wake_now) begin
                warm_r <= 1'b1;
            end else if (timeout || low_f) begin
                warm_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence refresh_seq;
        cpu.wdt_instr && !reset_ev;
    endsequence

    a_refresh_clears: assert property (refresh_seq |=> wdt_cnt_r == 24'd0)
        else $error("refresh did not clear counter");
    a_wake_div16_off: assert property (wake_pulse |-> !ctrl_r[F_DIV16])
        else $error("div16 not cleared by wake");
    a_wake_sets_warm: assert property (wake_pulse |-> warm_r)
        else $error("warm flag not set on wake");
    a_timeout_cold: assert property (wdt_reset |-> !warm_r && por_start)
        else $error("timeout did not start delay or clear warm");
    a_locked_mode_kept: assert property (
        (win_r == WIN_LOCKED && wr && hit_mode && !low_f) |=> $stable(mode_r))
        else $error("mode changed after window");
    a_low_holds_reset: assert property (low_f |=> global_reset)
        else $error("low supply without global reset");
    a_wake_disables: assert property (
        (wake_pulse && !PERMANENT) |-> !wdt_en_r)
        else $error("watchdog left running after wake");
    a_half_clock: assert property (
        (sclk_tick && ctrl_r[1:0] == 2'b00 && !cpu.stop_mode
         && $stable(ctrl_r)) |=> !sclk_tick)
        else $error("undivided tick at half rate");
    a_delay_on_wake: assert property (
        (wake_now && ctrl_r[F_DELAY]) |=> por_start)
        else $error("wake delay not started");

    // A timeout must not touch software state; only a wake, a control write or a low supply may clear div16
    a_timeout_keeps_regs: assert property (
        (timeout && !wr && !wake_now && !low_f)
        |=> $stable(ctrl_r) && $stable(extra_r) && $stable(mode_r))
        else $error("registers changed by timeout");
    // With the halt bit clear the count must freeze, or a halted part resets
    a_halt_freezes: assert property (
        (cpu.halt_mode && !mode_r[F_HALT] && !locked_on
         && !reset_ev && !cpu.wdt_instr && !low_f)
        |=> $stable(wdt_cnt_r))
        else $error("watchdog counted in halt");
endmodule

// ### logic/stop_wdt_pkg.sv
package stop_wdt_pkg;
    // ============================================================
    // Clock and timing
    localparam int CLK_PERIOD_NS   = 8;
    localparam int CLK_MHZ         = 1000 / CLK_PERIOD_NS;
    localparam int WIN_SCLK        = 60;   // Mode write window
    localparam int FAST_WAKE_TPC   = 5;    // Least wake hold
    localparam int WDT_RC_US0      = 3500;
    localparam int WDT_RC_US1      = 7000;
    localparam int WDT_RC_US2      = 14000;
    localparam int WDT_RC_US3      = 56000;
    localparam int WDT_RC_CYC0     = WDT_RC_US0 * CLK_MHZ;
    localparam int WDT_RC_CYC1     = WDT_RC_US1 * CLK_MHZ;
    localparam int WDT_RC_CYC2     = WDT_RC_US2 * CLK_MHZ;
    localparam int WDT_RC_CYC3     = WDT_RC_US3 * CLK_MHZ;
    localparam logic [11:0] WDT_SCLK0 = 12'h080;
    localparam logic [11:0] WDT_SCLK1 = 12'h100;
    localparam logic [11:0] WDT_SCLK2 = 12'h200;
    localparam logic [11:0] WDT_SCLK3 = 12'h800;
    // ============================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_CTRL   = 8'h0B;
    localparam logic [7:0] IDX_EXTRA  = 8'h0D;
    localparam logic [7:0] IDX_MODE   = 8'h0F;
    localparam logic [7:0] IDX_STATUS = 8'h10;
    // ============================================================
    // Field positions
    localparam int F_DIV16 = 0;
    localparam int F_NODIV = 1;
    localparam int F_SRC   = 2;    // Bits 4..2
    localparam int F_DELAY = 5;
    localparam int F_POL   = 6;
    localparam int F_WARM  = 7;
    localparam int F_TSEL  = 0;    // Bits 1..0
    localparam int F_HALT  = 2;
    localparam int F_STOP  = 3;
    localparam int F_XTAL  = 4;
    // ============================================================
    // Reset values
    localparam logic [6:0] CTRL_RST  = 7'h20;
    localparam logic [1:0] EXTRA_RST = 2'h0;
    localparam logic [4:0] MODE_RST  = 5'h0D;
    // ============================================================
    // Carriers
    typedef struct packed {
        logic [7:0] p2_in;     // Port 2 pin levels
        logic [7:0] p2_out;    // Port 2 driven levels
        logic [7:0] p2_is_out; // Port 2 direction, 1 = output
        logic [3:0] p3_in;     // Port 3 bits 3..0
    } wake_pins_s;
    typedef struct packed {
        logic halt_mode;       // CPU in HALT
        logic stop_mode;       // CPU in STOP
        logic first_instr;     // First instruction after reset
        logic wdt_instr;       // Watchdog refresh instruction
        logic analog_mode;     // Port 3 analog mode
    } cpu_state_s;
endpackage

// ### testbench/stop_recovery_and_watchdog_ctrl_test.sv
`timescale 1ns/1ps
// ============================================================
// Bench: register tasks, watchdog table, wake table, supply
module stop_recovery_and_watchdog_ctrl_test;
    import stop_wdt_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, supply_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, sclk_tick, wake_pulse, wdt_reset, por_start, global_reset;
    wake_pins_s  pins;
    cpu_state_s  cpu;
    logic        src_on, out_mode, err;
    logic [7:0]  p2_idle, p2_act;
    logic [3:0]  p3_act;
    int          n_mismatch, checks, n, k0, i;
    int          cyc      = 0;
    int          wake_cnt = 0;
    // Short RC counts keep the run brief
    stop_recovery_and_watchdog_ctrl #(.PERMANENT(1'b0), .RC_CYC0(200), .RC_CYC1(400),
        .RC_CYC2(800), .RC_CYC3(1600)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .cpu(cpu), .supply_low(supply_low),
        .sclk_tick(sclk_tick), .wake_pulse(wake_pulse), .wdt_reset(wdt_reset),
        .por_start(por_start), .global_reset(global_reset));
    wake_source_model u_pins (.pclk(pclk), .presetn(presetn), .src_on(src_on),
        .out_mode(out_mode), .p2_idle(p2_idle), .p2_act(p2_act), .p3_act(p3_act), .pins(pins));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Hang guard and wake event counter
    always @(posedge pclk) begin
        cyc++;
        if (wake_pulse === 1'b1) wake_cnt++;
        if (cyc == 40000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic cpu_pulse(input bit refresh);
        if (refresh) cpu.wdt_instr <= 1'b1;
        else cpu.first_instr <= 1'b1;
        @(posedge pclk);
        cpu.wdt_instr <= 1'b0;
        cpu.first_instr <= 1'b0;
    endtask
    task automatic wait_wdt(input int lim);
        n = 0;
        while (wdt_reset !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic ticks(input int c);
        n = 0;
        repeat (c) begin
            @(posedge pclk);
            if (sclk_tick === 1'b1) n++;
        end
    endtask
    // Tables: watchdog modes with expected counts, wake setups
    logic [7:0] modes [7] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h01, 8'h10, 8'h14};
    bit         halt  [7] = '{0, 0, 0, 0, 0, 1, 1};
    int         limit [7] = '{128, 256, 512, 2048, 400, 0, 128};
    logic [7:0] ctl   [7] = '{8'h64, 8'h14, 8'h58, 8'h5C, 8'h40, 8'h00, 8'h54};
    logic [1:0] ext   [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    logic [7:0] p2i   [7] = '{8'h00, 8'hFF, 8'h0F, 8'h01, 8'h07, 8'hFF, 8'h00};
    logic [7:0] p2a   [7] = '{8'h00, 8'h7F, 8'hF0, 8'h00, 8'h0F, 8'hFE, 8'h80};
    initial begin
        {presetn, psel, penable, pwrite, supply_low, src_on, out_mode} = 7'h00;
        {paddr, pwdata, p2_idle, p2_act, p3_act} = '0;
        cpu = '0;
        n_mismatch = 0;
        checks = 0;
        wt(20);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h02C, 32'h0);
        check("control", rd, 32'h0);
        apb(1'b0, 12'h03C, 32'h0);
        check("mode read", rd, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        check("watchdog on", rd[2], 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped", err, 1'b1);
        ticks(64);
        check("half rate", n, 32);
        apb(1'b1, 12'h02C, 32'h22);
        wt(8);
        ticks(64);
        check("full rate", n, 64);
        // Each case reopens the window and times the watchdog
        for (i = 0; i < 7; i++) begin
            cpu_pulse(0);
            apb(1'b1, 12'h03C, {24'h0, modes[i]});
            cpu.halt_mode <= halt[i];
            cpu_pulse(1);
            wait_wdt(2100);
            if (limit[i] == 0) check("halt hold", n, 2100);
            else begin
                check("timeout", n >= limit[i] - 1 && n <= limit[i] + 2, 1);
                check("timeout delay", por_start, 1'b1);
            end
            cpu.halt_mode <= 1'b0;
            if (wdt_reset !== 1'b1) wait_wdt(300);
            wt(2);
        end
        // Late mode write is dropped; refreshes restart the count
        cpu_pulse(0);
        apb(1'b1, 12'h03C, 32'h10);
        cpu_pulse(1);
        wt(60);
        apb(1'b1, 12'h03C, 32'h13);
        cpu_pulse(1);
        apb(1'b0, 12'h040, 32'h0);
        check("locked", rd[5], 1'b1);
        wt(100);
        cpu_pulse(1);
        wait_wdt(2100);
        check("refresh count", n >= 127 && n <= 130, 1);
        wt(2);
        apb(1'b0, 12'h02C, 32'h0);
        check("cold after timeout", rd, 32'h0);
        // Second reset leaves the watchdog off for the wake cases
        presetn <= 1'b0;
        wt(3);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 7; i++) begin
            p2_idle <= p2i[i];
            p2_act <= p2a[i];
            p3_act <= {3'h0, i == 0};
            out_mode <= (i == 6);
            apb(1'b1, 12'h02C, {24'h0, ctl[i] | 8'h03});
            apb(1'b1, 12'h034, {30'h0, ext[i]});
            cpu.stop_mode <= 1'b1;
            k0 = wake_cnt;
            wt(10);
            check("no idle wake", wake_cnt, k0);
            src_on <= 1'b1;
            n = 0;
            while (wake_pulse !== 1'b1 && n < 30) begin
                @(posedge pclk);
                n++;
            end
            check("wake", wake_pulse, 1'b1);
            check("wake delay", por_start, ctl[i][5]);
            src_on <= 1'b0;
            cpu.stop_mode <= 1'b0;
            wt(2);
            apb(1'b0, 12'h02C, 32'h0);
            check("warm", rd, 32'h80);
            ticks(32);
            check("prescale off", n, 32);
        end
        // Timeout inside STOP on the RC clock: registers kept, delay forced
        cpu_pulse(0);
        apb(1'b1, 12'h03C, 32'h09);
        cpu.stop_mode <= 1'b1;
        cpu_pulse(1);
        wait_wdt(500);
        check("stop timeout", n >= 399 && n <= 402, 1);
        check("stop timeout delay", por_start, 1'b1);
        cpu.stop_mode <= 1'b0;
        wt(2);
        apb(1'b0, 12'h02C, 32'h0);
        check("cold after stop timeout", rd, 32'h0);
        ticks(32);
        check("clock select kept", n, 32);
        supply_low <= 1'b1;
        wt(8);
        check("low supply", global_reset, 1'b1);
        supply_low <= 1'b0;
        n = 0;
        while (por_start !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check("power good delay", por_start, 1'b1);
        print_verdict();
    end
endmodule

// ### testbench/wake_source_model.sv
`timescale 1ns/1ps
// ============================================================
// Far side pins: holds a wake source up, mimics released lines
module wake_source_model (
    input  wire logic                pclk,     // Clock
    input  wire logic                presetn,  // Reset, low
    input  wire logic                src_on,   // Raise the wake source
    input  wire logic                out_mode, // Port 2 driven by the core
    input  wire logic [7:0]          p2_idle,  // Port 2 idle level
    input  wire logic [7:0]          p2_act,   // Port 2 active level
    input  wire logic [3:0]          p3_act,   // Port 3 active level
    output stop_wdt_pkg::wake_pins_s pins      // Pins to the block
);
    import stop_wdt_pkg::*;
    logic [2:0] hold_r; // Cycles the source still stays up
    logic [7:0] junk_r; // Undriven output latch pattern
    wire        active = src_on | (hold_r != 3'h0);
    wire  [7:0] p2_lvl = active ? p2_act : p2_idle;
    // Source stays up a few clocks after the request drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 3'h0;
            junk_r <= 8'h5A;
        end else begin
            hold_r <= src_on ? 3'(FAST_WAKE_TPC) : hold_r - 3'(hold_r != 3'h0);
            junk_r <= ~junk_r;
        end
    end
    // A released output latch never shows a stable last value
    assign pins.p2_is_out = out_mode ? 8'hFF : 8'h00;
    assign pins.p2_out    = out_mode ? p2_lvl : junk_r;
    assign pins.p2_in     = out_mode ? ~p2_lvl : p2_lvl;
    assign pins.p3_in     = active ? p3_act : 4'h0;
endmodule
